// *** core/pid_loop_controller.sv ***
// Sampled loop controller, position and velocity forms
// Function
// - Position or velocity output form
// - Coefficients scale with gain when gain nonzero
// - Derivative uses process value change
// - Bias integrates error, output sums terms
// - Normalized output clamped to zero..one
// - Programmable output limits within 0..4095
// - Bias kept within zero..one
// - Freeze bias while output saturates
// - Otherwise recompute bias from clamped output
// - Setpoint step scales bias by ratio
// - Reset interval 9999 or 0000 disables integral
// - Zero rate span removes derivative
// - Zero gain: no proportional, unscaled coefficients
// - Velocity form outputs change from previous
// - Manual to auto loads setpoint from PV, and bias except in velocity form without type 2
// - Four process value limit alarms
// - Yellow and orange deviation alarm pairs
// - Rate-of-change alarm
// - Hysteresis band on limit and deviation alarms
// - Manual output from operator, alarms kept
// - Automatic computes output, alarms kept
// - Cascade takes setpoint from other loop
// - Reverse acting negates error effects
`timescale 1ns/10ps
module pid_loop_controller
  import pid_pkg::*;
(
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          RESETN,
  // Sample tick and inputs
  input  wire logic          SAMPLE_TICK,
  input  wire logic [15:0]   PROCESS_VALUE,
  input  wire logic [15:0]   SETPOINT_IN,
  input  wire logic [15:0]   CASCADE_SETPOINT,
  input  wire logic [15:0]   MANUAL_OUTPUT,
  input  wire logic [15:0]   MANUAL_BIAS,
  input  wire logic [15:0]   INITIAL_OUTPUT,
  // Tuning, Q8.8 gain and plain integer times
  input  wire logic [15:0]   PROPORTIONAL_GAIN,
  input  wire logic [15:0]   SAMPLE_PERIOD,
  input  wire logic [15:0]   RESET_INTERVAL,
  input  wire logic [15:0]   RATE_SPAN,
  // Options
  input  wire logic [1:0]    MODE,
  input  wire logic          VELOCITY_FORM,
  input  wire logic          REVERSE_ACTING,
  input  wire logic          FREEZE_BIAS,
  input  wire logic          STEP_BIAS,
  input  wire logic          BUMPLESS_TYPE2,
  input  wire logic [15:0]   OUTPUT_MIN,
  input  wire logic [15:0]   OUTPUT_MAX,
  // Alarm limits
  input  wire logic [15:0]   LIMIT_HH,
  input  wire logic [15:0]   LIMIT_H,
  input  wire logic [15:0]   LIMIT_L,
  input  wire logic [15:0]   LIMIT_LL,
  input  wire logic [15:0]   DEV_YELLOW,
  input  wire logic [15:0]   DEV_ORANGE,
  input  wire logic [15:0]   RATE_LIMIT,
  input  wire logic [15:0]   HYSTERESIS,
  // Results
  output logic [15:0]        CONTROL_OUTPUT,
  output logic signed [16:0] OUTPUT_DELTA,
  output logic [15:0]        BIAS_TERM,
  output logic [15:0]        SETPOINT_USED,
  output logic [8:0]         ALARMS,
  output logic               DONE
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic        tick_s1_q, tick_s2_q, tick_s3_q;
  logic [15:0] pv_s1_q, pv_s2_q;
  logic        tick_p;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
      pv_s1_q   <= '0;
      pv_s2_q   <= '0;
    end else begin
      tick_s1_q <= SAMPLE_TICK;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      pv_s1_q   <= PROCESS_VALUE;
      pv_s2_q   <= pv_s1_q;
    end
  end
  assign tick_p = tick_s2_q & ~tick_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // Loop state
  calc_state_t        st_q, st_d;
  logic signed [31:0] bias_q, bias_d;
  logic [15:0]        out_q, out_d;
  logic signed [16:0] dout_q, dout_d;
  logic [15:0]        pv_prev_q, pv_prev_d;
  logic [15:0]        sp_q, sp_d;
  logic [15:0]        sp_prev_q, sp_prev_d;
  logic [1:0]         mode_q, mode_d;
  logic               done_q, done_d;
  logic signed [31:0] ki_q, ki_d;
  logic signed [31:0] kr_q, kr_d;
  logic [15:0]        pv_s_q, pv_s_d;
  logic               init_q, init_d;
  logic               alarm_tick;

  // Combinational math
  logic signed [31:0] err, dpv, p_term, i_term, d_term, m_raw, bias_new, bias_lim;
  logic signed [31:0] lo_lim, hi_lim, m_clamp, full;
  logic signed [47:0] prod_p, prod_i, prod_d, prod_s;
  logic               sat, integ_off, sp_src_auto;
  logic [15:0]        sp_target;

  function automatic logic signed [31:0] clip(input logic signed [31:0] v,
                                              input logic signed [31:0] lo,
                                              input logic signed [31:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_comb begin
    full        = {16'h0000, FULL_SCALE};
    lo_lim      = {16'h0000, OUTPUT_MIN};
    hi_lim      = {16'h0000, OUTPUT_MAX};
    if (hi_lim > full) hi_lim = full;
    sp_target   = (MODE == MODE_CASC) ? CASCADE_SETPOINT : SETPOINT_IN;
    err         = $signed({16'h0000, sp_q}) - $signed({16'h0000, pv_s_q});
    dpv         = $signed({16'h0000, pv_s_q}) - $signed({16'h0000, pv_prev_q});
    integ_off   = (RESET_INTERVAL == TI_OFF_A) || (RESET_INTERVAL == TI_OFF_B);
    // Proportional gain is Q8.8, zero gain drops the term
    prod_p      = $signed({16'h0000, PROPORTIONAL_GAIN}) * err;
    p_term      = 32'(prod_p >>> FRAC);
    prod_i      = ki_q * err;
    i_term      = integ_off ? 32'sd0 : 32'(prod_i >>> FRAC);
    prod_d      = kr_q * dpv;
    d_term      = (RATE_SPAN == 16'h0000) ? 32'sd0 : 32'(prod_d >>> FRAC);
    if (REVERSE_ACTING) begin
      bias_new = bias_q - i_term;
      m_raw    = -p_term + d_term + bias_new;
    end else begin
      bias_new = bias_q + i_term;
      m_raw    = p_term - d_term + bias_new;
    end
    m_clamp     = clip(clip(m_raw, 32'sd0, full), lo_lim, hi_lim);
    sat         = (m_raw < 32'sd0) || (m_raw > full);
    if (!sat) begin
      bias_lim = bias_new;
    end else if (FREEZE_BIAS) begin
      bias_lim = bias_q;
    end else if (REVERSE_ACTING) begin
      bias_lim = m_clamp + p_term - d_term;
    end else begin
      bias_lim = m_clamp - p_term + d_term;
    end
    bias_lim    = clip(bias_lim, 32'sd0, full);
    prod_s      = 48'sd0;
    sp_src_auto = (MODE != MODE_MAN);
  end

  always_comb begin
    logic [31:0] ratio_num;
    logic [31:0] ratio_den;
    ratio_num = 32'h0000_0000;
    ratio_den = 32'h0000_0001;
    st_d      = st_q;
    bias_d    = bias_q;
    out_d     = out_q;
    dout_d    = dout_q;
    pv_prev_d = pv_prev_q;
    sp_d      = sp_q;
    sp_prev_d = sp_prev_q;
    mode_d    = mode_q;
    ki_d      = ki_q;
    kr_d      = kr_q;
    pv_s_d    = pv_s_q;
    done_d    = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (tick_p) begin
          pv_s_d = pv_s2_q;
          // First sample starts from initial output
          if (!init_q) begin
            bias_d = {16'h0000, INITIAL_OUTPUT};
          end
          st_d   = ST_COEF;
        end
      end
      ST_COEF: begin
        // Coefficients in Q8.8
        if (PROPORTIONAL_GAIN != 16'h0000) begin
          ki_d = integ_off ? 32'sd0 : 32'(($signed({16'h0000, PROPORTIONAL_GAIN}) *
                 $signed({16'h0000, SAMPLE_PERIOD})) / $signed({16'h0000, RESET_INTERVAL}));
          kr_d = (SAMPLE_PERIOD == 16'h0000) ? 32'sd0 : 32'(($signed({16'h0000, PROPORTIONAL_GAIN}) *
                 $signed({16'h0000, RATE_SPAN})) / $signed({16'h0000, SAMPLE_PERIOD}));
        end else begin
          ki_d = integ_off ? 32'sd0 : 32'($signed({8'h00, SAMPLE_PERIOD, 8'h00}) /
                 $signed({16'h0000, RESET_INTERVAL}));
          kr_d = (SAMPLE_PERIOD == 16'h0000) ? 32'sd0 : 32'($signed({8'h00, RATE_SPAN, 8'h00}) /
                 $signed({16'h0000, SAMPLE_PERIOD}));
        end
        mode_d = MODE;
        if (mode_q == MODE_MAN && MODE != MODE_MAN) begin
          sp_d      = pv_s_q;
          sp_prev_d = pv_s_q;
          if (!VELOCITY_FORM || BUMPLESS_TYPE2) bias_d = {16'h0000, out_q};
        end else if (sp_src_auto) begin
          sp_prev_d = sp_q;
          sp_d      = sp_target;
          if (STEP_BIAS && sp_target != sp_q && sp_q != 16'h0000 && sp_target != 16'h0000) begin
            ratio_num = REVERSE_ACTING ? {16'h0000, sp_q} : {16'h0000, sp_target};
            ratio_den = REVERSE_ACTING ? {16'h0000, sp_target} : {16'h0000, sp_q};
            bias_d    = clip(32'($signed(48'(bias_q) * $signed({16'h0000, ratio_num}))
                        / $signed({16'h0000, ratio_den})), 32'sd0, full);
          end
        end else begin
          sp_d = SETPOINT_IN;
        end
        st_d = ST_CALC;
      end
      ST_CALC: begin
        if (mode_q == MODE_MAN) begin
          out_d  = MANUAL_OUTPUT;
          bias_d = integ_off ? {16'h0000, MANUAL_BIAS} : bias_q;
        end else begin
          out_d  = m_clamp[15:0];
          bias_d = (integ_off && !sat) ? {16'h0000, MANUAL_BIAS} : bias_lim;
        end
        st_d = ST_STORE;
      end
      ST_STORE: begin
        dout_d    = $signed({1'b0, out_q}) - $signed({1'b0, CONTROL_OUTPUT});
        pv_prev_d = pv_s_q;
        done_d    = 1'b1;
        st_d      = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output holding between samples
  logic [15:0] held_q, held_d;
  logic [15:0] bias_out_q, bias_out_d;
  assign held_d     = (st_q == ST_STORE) ? out_q : held_q;
  assign bias_out_d = (st_q == ST_STORE) ? bias_q[15:0] : bias_out_q;

  ////////////////////////////////////////////////////////////////////////
  // Loop registers

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q      <= ST_IDLE;
      bias_q    <= '0;
      out_q     <= '0;
      dout_q    <= '0;
      pv_prev_q <= '0;
      sp_q      <= '0;
      sp_prev_q <= '0;
      mode_q    <= MODE_MAN;
      ki_q      <= '0;
      kr_q      <= '0;
      pv_s_q    <= '0;
      done_q    <= 1'b0;
      held_q    <= '0;
      bias_out_q <= '0;
    end else begin
      st_q      <= st_d;
      bias_q    <= bias_d;
      out_q     <= out_d;
      dout_q    <= dout_d;
      pv_prev_q <= pv_prev_d;
      sp_q      <= sp_d;
      sp_prev_q <= sp_prev_d;
      mode_q    <= mode_d;
      ki_q      <= ki_d;
      kr_q      <= kr_d;
      pv_s_q    <= pv_s_d;
      done_q    <= done_d;
      held_q    <= held_d;
      bias_out_q <= bias_out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bias starts at initial output on first sample
  assign init_d = init_q | (st_q == ST_STORE);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      init_q <= 1'b0;
    end else begin
      init_q <= init_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarms evaluated every sample in every mode
  assign alarm_tick = (st_q == ST_STORE);

  pid_alarm u_alarm (
    .clk      (CLK),
    .resetn   (RESETN),
    .tick     (alarm_tick),
    .pv       (pv_s_q),
    .pv_prev  (pv_prev_q),
    .sp       (sp_q),
    .lim_hh   (LIMIT_HH),
    .lim_h    (LIMIT_H),
    .lim_l    (LIMIT_L),
    .lim_ll   (LIMIT_LL),
    .dev_y    (DEV_YELLOW),
    .dev_o    (DEV_ORANGE),
    .rate_lim (RATE_LIMIT),
    .hyst     (HYSTERESIS),
    .alarms   (ALARMS)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign CONTROL_OUTPUT = held_q;
  assign OUTPUT_DELTA   = dout_q;
  assign BIAS_TERM      = init_q ? bias_out_q : INITIAL_OUTPUT;
  assign SETPOINT_USED  = sp_q;
  assign DONE           = done_q;
endmodule

// *** core/pid_pkg.sv ***
// Shared constants and types for the sampled loop controller
package pid_pkg;
  // Data formats: 16-bit unsigned values, coefficients Q8.8 signed
  localparam int DW        = 16;
  localparam int CW        = 16;
  localparam int FRAC      = 8;
  localparam int NORM_BITS = 12;
  localparam logic [15:0] OUT_MIN_RST = 16'h0000;
  localparam logic [15:0] OUT_MAX_RST = 16'h0FFF;
  localparam logic [15:0] FULL_SCALE  = 16'h0FFF;
  localparam logic [15:0] TI_OFF_A    = 16'h9999;
  localparam logic [15:0] TI_OFF_B    = 16'h0000;
  localparam logic [1:0]  MODE_MAN    = 2'h0;
  localparam logic [1:0]  MODE_AUTO   = 2'h1;
  localparam logic [1:0]  MODE_CASC   = 2'h2;
  localparam int ALARM_BITS = 9;
  typedef enum logic [1:0] {ST_IDLE, ST_COEF, ST_CALC, ST_STORE} calc_state_t;
endpackage

// *** core/pid_alarm.sv ***
// Limit and deviation alarms with hysteresis, plus a rate alarm without it
`timescale 1ns/10ps
module pid_alarm
  import pid_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // Sample
  input  wire logic          tick,
  input  wire logic [15:0]   pv,
  input  wire logic [15:0]   pv_prev,
  input  wire logic [15:0]   sp,
  // Limits
  input  wire logic [15:0]   lim_hh,
  input  wire logic [15:0]   lim_h,
  input  wire logic [15:0]   lim_l,
  input  wire logic [15:0]   lim_ll,
  input  wire logic [15:0]   dev_y,
  input  wire logic [15:0]   dev_o,
  input  wire logic [15:0]   rate_lim,
  input  wire logic [15:0]   hyst,
  // Alarm bits: hh,h,l,ll,yh,yl,oh,ol,roc
  output logic [8:0]         alarms
);
  logic [8:0]  alarm_q;
  logic [8:0]  alarm_d;
  logic [17:0] pvx;
  logic [17:0] spx;
  logic [17:0] hy;
  logic [17:0] thr_hi [0:5];
  logic [17:0] thr_lo [0:5];
  logic [17:0] delta;

  assign pvx = {2'b00, pv};
  assign spx = {2'b00, sp};
  assign hy  = {2'b00, hyst};
  // High-type thresholds: hh, h, yellow high, orange high
  assign thr_hi[0] = {2'b00, lim_hh};
  assign thr_hi[1] = {2'b00, lim_h};
  assign thr_hi[2] = spx + {2'b00, dev_y};
  assign thr_hi[3] = spx + {2'b00, dev_o};
  // Low-type thresholds: l, ll, yellow low, orange low
  assign thr_lo[0] = {2'b00, lim_l};
  assign thr_lo[1] = {2'b00, lim_ll};
  assign thr_lo[2] = spx - {2'b00, dev_y};
  assign thr_lo[3] = spx - {2'b00, dev_o};
  assign thr_hi[4] = '0;
  assign thr_hi[5] = '0;
  assign thr_lo[4] = '0;
  assign thr_lo[5] = '0;
  assign delta = (pv >= pv_prev) ? {2'b00, pv - pv_prev} : {2'b00, pv_prev - pv};

  always_comb begin
    int k;
    k       = 0;
    alarm_d = alarm_q;
    if (tick) begin
      for (k = 0; k < 4; k++) begin
        // Highs set above threshold, clear at or below threshold minus band; lows mirror this
        if ($signed(pvx) > $signed(thr_hi[k])) begin
          alarm_d[k * 2] = 1'b1;
        end else if ($signed(pvx) + $signed(hy) <= $signed(thr_hi[k])) begin
          alarm_d[k * 2] = 1'b0;
        end
        if ($signed(pvx) < $signed(thr_lo[k])) begin
          alarm_d[k * 2 + 1] = 1'b1;
        end else if ($signed(pvx) >= $signed(thr_lo[k]) + $signed(hy)) begin
          alarm_d[k * 2 + 1] = 1'b0;
        end
      end
      alarm_d[8] = delta > {2'b00, rate_lim};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // Reorder to hh,h,l,ll,yh,yl,oh,ol,roc
  assign alarms = {alarm_q[8], alarm_q[7], alarm_q[6], alarm_q[5], alarm_q[4],
                   alarm_q[3], alarm_q[1], alarm_q[2], alarm_q[0]};
endmodule

// *** tb/proc_io_model.sv ***
// Behavioural sensor and actuator modules at the far side
`timescale 1ns/10ps
module proc_io_model (
  // Clock
  input  wire logic        clk,
  // Sensor side
  input  wire logic [15:0] pv_level,
  output logic      [15:0] pv_out,
  // Actuator side
  input  wire logic        done,
  input  wire logic [15:0] drive_in,
  output logic      [15:0] actuator
);
  logic done_q = 1'b0;
  initial pv_out = 16'h0000;
  initial actuator = 16'h0000;
  // Converter settles one cycle after the field level
  always @(posedge clk) pv_out <= pv_level;
  // Actuator takes the output once a sample is complete
  always @(posedge clk) begin
    done_q <= done;
    if (done_q) actuator <= drive_in;
  end
endmodule

// *** tb/pid_loop_checker.sv ***
// Port-level assertions for the loop controller
`timescale 1ns/10ps
module pid_loop_checker
  import pid_pkg::*;
(
  // Clock, reset and inputs
  input wire logic               CLK,
  input wire logic               RESETN,
  input wire logic               SAMPLE_TICK,
  input wire logic [15:0]        PROCESS_VALUE,
  input wire logic [15:0]        CASCADE_SETPOINT,
  input wire logic [15:0]        MANUAL_OUTPUT,
  input wire logic [1:0]         MODE,
  input wire logic               VELOCITY_FORM,
  input wire logic [15:0]        OUTPUT_MIN,
  input wire logic [15:0]        OUTPUT_MAX,
  input wire logic [15:0]        LIMIT_HH,
  input wire logic [15:0]        LIMIT_H,
  input wire logic [15:0]        HYSTERESIS,
  // Outputs
  input wire logic [15:0]        CONTROL_OUTPUT,
  input wire logic signed [16:0] OUTPUT_DELTA,
  input wire logic [15:0]        BIAS_TERM,
  input wire logic [15:0]        SETPOINT_USED,
  input wire logic [8:0]         ALARMS,
  input wire logic               DONE
);
  logic [3:0] age_q, age_d;
  logic       tick_q, tick_d;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Cycles since the last tick edge
  always_comb begin
    tick_d = SAMPLE_TICK;
    age_d  = (age_q == 4'hF) ? age_q : age_q + 4'h1;
    if (SAMPLE_TICK && !tick_q) age_d = 4'h0;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      age_q  <= 4'hF;
      tick_q <= 1'b0;
    end else begin
      age_q  <= age_d;
      tick_q <= tick_d;
    end
  end
  a_done_pulse: assert property (DONE |=> !DONE) else $error("done too long");
  a_outputs_held: assert property (!DONE |-> $stable({CONTROL_OUTPUT, OUTPUT_DELTA, BIAS_TERM, ALARMS}))
    else $error("output moved between samples");
  a_tick_answer: assert property ($rose(SAMPLE_TICK) |-> ##[2:10] DONE) else $error("tick unanswered");
  a_done_cause: assert property (DONE |-> age_q >= 4'h2 && age_q <= 4'hA) else $error("done without tick");
  a_auto_limits: assert property ($past(DONE) && MODE != MODE_MAN && !VELOCITY_FORM && OUTPUT_MIN <= OUTPUT_MAX
    && OUTPUT_MAX <= FULL_SCALE |-> CONTROL_OUTPUT >= OUTPUT_MIN && CONTROL_OUTPUT <= OUTPUT_MAX)
    else $error("output outside limits");
  a_manual_follow: assert property ($past(DONE) && MODE == MODE_MAN && $past(MODE, 8) == MODE_MAN
    && $past(MANUAL_OUTPUT, 8) == MANUAL_OUTPUT && MANUAL_OUTPUT >= OUTPUT_MIN && MANUAL_OUTPUT <= OUTPUT_MAX
    |-> CONTROL_OUTPUT == MANUAL_OUTPUT) else $error("manual output not followed");
  a_cascade_sp: assert property ($past(DONE) && MODE == MODE_CASC && $past(MODE, 8) == MODE_CASC
    && $past(CASCADE_SETPOINT, 8) == CASCADE_SETPOINT |-> SETPOINT_USED == CASCADE_SETPOINT)
    else $error("cascade setpoint not used");
  a_high_high: assert property ($past(DONE) && PROCESS_VALUE > LIMIT_HH
    && $past(PROCESS_VALUE, 8) == PROCESS_VALUE |-> ALARMS[0]) else $error("high-high alarm missing");
  a_high_hyst: assert property ($past(DONE) && $past(ALARMS[1]) && $past(PROCESS_VALUE, 8) == PROCESS_VALUE
    && {1'b0, PROCESS_VALUE} + {1'b0, HYSTERESIS} > {1'b0, LIMIT_H} |-> ALARMS[1])
    else $error("high alarm cleared inside band");
endmodule

bind pid_loop_controller pid_loop_checker chk (.CLK(CLK), .RESETN(RESETN), .SAMPLE_TICK(SAMPLE_TICK),
  .PROCESS_VALUE(PROCESS_VALUE), .CASCADE_SETPOINT(CASCADE_SETPOINT), .MANUAL_OUTPUT(MANUAL_OUTPUT),
  .MODE(MODE), .VELOCITY_FORM(VELOCITY_FORM), .OUTPUT_MIN(OUTPUT_MIN), .OUTPUT_MAX(OUTPUT_MAX),
  .LIMIT_HH(LIMIT_HH), .LIMIT_H(LIMIT_H), .HYSTERESIS(HYSTERESIS), .CONTROL_OUTPUT(CONTROL_OUTPUT),
  .OUTPUT_DELTA(OUTPUT_DELTA), .BIAS_TERM(BIAS_TERM), .SETPOINT_USED(SETPOINT_USED), .ALARMS(ALARMS),
  .DONE(DONE));

// *** tb/pid_loop_controller_test.sv ***
// Self-checking bench for the sampled loop controller
`timescale 1ns/10ps
module pid_loop_controller_test
  import pid_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, vel = 1'b0, rev = 1'b0, frz = 1'b1;
  logic [1:0] mode = MODE_MAN;
  logic [15:0] pv_level = 16'h0600, pv, sp = 16'h0600, ti = 16'h0000;
  logic [15:0] cout, bias, sp_used, act;
  logic [15:0] csp = 16'h0900, mout = 16'h0400, mbias = 16'h0400, gain = 16'h0100, omin = 16'h0100;
  logic [15:0] omax = 16'h0C00, lhh = 16'h0C80, lh = 16'h0C00, ll = 16'h0200, lll = 16'h0100;
  logic [15:0] devy = 16'h0300, devo = 16'h0600, rlim = 16'h0800, hys = 16'h0040;
  logic signed [16:0] delta;
  logic [8:0] alarms;
  logic done;
  int checked = 0, miscompares = 0;

  initial forever #4 clk = ~clk;

  proc_io_model io (.clk(clk), .pv_level(pv_level), .pv_out(pv), .done(done), .drive_in(cout), .actuator(act));

  pid_loop_controller DUT (.CLK(clk), .RESETN(rst_n), .SAMPLE_TICK(tick), .PROCESS_VALUE(pv),
    .SETPOINT_IN(sp), .CASCADE_SETPOINT(csp), .MANUAL_OUTPUT(mout), .MANUAL_BIAS(mbias),
    .INITIAL_OUTPUT(16'h0400), .PROPORTIONAL_GAIN(gain), .SAMPLE_PERIOD(16'h0010),
    .RESET_INTERVAL(ti), .RATE_SPAN(16'h0000), .MODE(mode), .VELOCITY_FORM(vel), .REVERSE_ACTING(rev),
    .FREEZE_BIAS(frz), .STEP_BIAS(1'b0), .BUMPLESS_TYPE2(1'b0), .OUTPUT_MIN(omin),
    .OUTPUT_MAX(omax), .LIMIT_HH(lhh), .LIMIT_H(lh), .LIMIT_L(ll),
    .LIMIT_LL(lll), .DEV_YELLOW(devy), .DEV_ORANGE(devo), .RATE_LIMIT(rlim),
    .HYSTERESIS(hys), .CONTROL_OUTPUT(cout), .OUTPUT_DELTA(delta), .BIAS_TERM(bias),
    .SETPOINT_USED(sp_used), .ALARMS(alarms), .DONE(done));

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One sample: set inputs, tick, wait, compare
  task automatic row(input logic [1:0] md, input logic [15:0] ri, input logic r, input logic v,
                     input logic [15:0] s, input logic [15:0] p, input logic [15:0] eo,
                     input logic [15:0] ea, input logic [15:0] es, input logic [8:0] eal,
                     input logic [16:0] ed);
    int n;
    @(posedge clk);
    #1 mode = md;
    ti = ri;
    rev = r;
    vel = v;
    sp = s;
    pv_level = p;
    repeat (3) @(posedge clk);
    #1 tick = 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 20) begin
      miscompares++;
      conclude();
    end
    repeat (2) @(posedge clk);
    #1 tick = 1'b0;
    if (eo != 16'hFFFF) chk("actuator", act, {1'b0, eo});
    chk("bias", bias, {1'b0, ea});
    if (es != 16'hFFFF) chk("setpoint", sp_used, {1'b0, es});
    chk("alarms", {8'h00, alarms}, {8'h00, eal});
    if (ed != 17'h10000) chk("delta", delta, ed);
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("reset out", cout, 17'h00000);
    chk("reset bias", bias, 17'h00400);
    row(MODE_MAN, 16'h0000, 0, 0, 16'h0600, 16'h0600, 16'h0400, 16'h0400, 16'hFFFF, 9'h000, 17'h10000);
    row(MODE_MAN, 16'h0000, 0, 0, 16'h0600, 16'h0D00, 16'h0400, 16'h0400, 16'hFFFF, 9'h053, 17'h10000);
    row(MODE_MAN, 16'h0000, 0, 0, 16'h0600, 16'h0600, 16'h0400, 16'h0400, 16'hFFFF, 9'h000, 17'h10000);
    row(MODE_AUTO, 16'h0000, 0, 0, 16'h0900, 16'h0600, 16'h0400, 16'h0400, 16'h0600, 9'h000, 17'h00000);
    row(MODE_AUTO, 16'h0000, 0, 0, 16'h0800, 16'h0700, 16'h0500, 16'h0400, 16'h0800, 9'h000, 17'h00100);
    row(MODE_AUTO, 16'h0000, 0, 0, 16'h0800, 16'h0C20, 16'h0100, 16'h0400, 16'h0800, 9'h012, 17'h1FC00);
    row(MODE_AUTO, 16'h0000, 0, 0, 16'h0800, 16'h0BE0, 16'h0100, 16'h0400, 16'h0800, 9'h012, 17'h00000);
    row(MODE_AUTO, 16'h0000, 0, 0, 16'h0800, 16'h0BB0, 16'h0100, 16'h0400, 16'h0800, 9'h010, 17'h00000);
    row(MODE_AUTO, 16'h9999, 0, 0, 16'h0800, 16'h0100, 16'h0B00, 16'h0400, 16'h0800, 9'h1A4, 17'h00A00);
    row(MODE_AUTO, 16'h9999, 0, 0, 16'h0800, 16'h0080, 16'h0B80, 16'h0400, 16'h0800, 9'h0AC, 17'h00080);
    row(MODE_AUTO, 16'h9999, 0, 0, 16'h0F00, 16'h0080, 16'h0C00, 16'h0400, 16'h0F00, 9'h0AC, 17'h00080);
    row(MODE_AUTO, 16'h9999, 1, 0, 16'h0800, 16'h0700, 16'h0300, 16'h0400, 16'h0800, 9'h000, 17'h1F700);
    row(MODE_AUTO, 16'h9999, 0, 1, 16'h0800, 16'h0500, 16'hFFFF, 16'h0400, 16'h0800, 9'h000, 17'h00400);
    row(MODE_CASC, 16'h9999, 0, 0, 16'h0100, 16'h0500, 16'h0800, 16'h0400, 16'h0900, 9'h020, 17'h10000);
    row(MODE_AUTO, 16'h0010, 0, 0, 16'h0800, 16'h0700, 16'h0600, 16'h0500, 16'h0800, 9'h000, 17'h1FE00);
    row(MODE_AUTO, 16'h0010, 0, 0, 16'h0800, 16'h0700, 16'h0700, 16'h0600, 16'h0800, 9'h000, 17'h00100);
    conclude();
  end
endmodule
